// file: hdl/cdlac_pkg.sv
// constants shared by the change-detect latch/axis config block
// assumes one 125 mhz clock, axi4-lite access, odr ticks from the sensor pipeline
// Behaviour
// - 8-bit config register: latch and axis enables
// - strap low clears all; high sets outside axes
// - outside flags follow condition when not latched
// - latched outside flags cleared only by read
// - latched outside active only on rising condition
// - latched inside flags cleared only by read
// - inside flags follow condition when not latched
// - latched inside active only on rising condition
// - x outside enable includes or excludes x
// - other axis enables include or exclude axes
// - no inside axes enabled: inside detection off
package cdlac_pkg;
  localparam int unsigned CDLAC_AW   = 8;
  localparam int unsigned CDLAC_DW   = 32;
  localparam int unsigned CDLAC_IW   = 6;
  localparam int unsigned CDLAC_AXES = 3;
  localparam int unsigned CDLAC_IRQW = 2;

  // register indices; byte address is four times the index
  localparam logic [CDLAC_IW-1:0] CDLAC_IDX_CONFIG  = 6'h2f;
  localparam logic [CDLAC_IW-1:0] CDLAC_IDX_OUT_SRC = 6'h20;
  localparam logic [CDLAC_IW-1:0] CDLAC_IDX_IN_SRC  = 6'h21;
  localparam logic [CDLAC_IW-1:0] CDLAC_IDX_STATUS  = 6'h22;
  localparam logic [CDLAC_IW-1:0] CDLAC_IDX_MASK    = 6'h23;

  // config fields
  localparam int unsigned CDLAC_BIT_OUT_LATCH = 7;
  localparam int unsigned CDLAC_BIT_IN_LATCH  = 6;
  localparam int unsigned CDLAC_OUT_AXIS_LSB  = 3;
  localparam int unsigned CDLAC_IN_AXIS_LSB   = 0;
  localparam logic [7:0]  CDLAC_CFG_RST_LOW   = 8'h00;
  localparam logic [7:0]  CDLAC_CFG_RST_HIGH  = 8'h38;

  // source register layout
  localparam int unsigned CDLAC_SRC_ACTIVE = 7;
  localparam int unsigned CDLAC_SRC_X      = 5;
  localparam int unsigned CDLAC_SRC_Y      = 3;
  localparam int unsigned CDLAC_SRC_Z      = 1;

  // interrupt status bits
  localparam int unsigned CDLAC_IRQ_OUT = 0;
  localparam int unsigned CDLAC_IRQ_IN  = 1;

  localparam logic [1:0] CDLAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CDLAC_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {CDLAC_RD_IDLE, CDLAC_RD_RESP} cdlac_rd_state_type;
endpackage : cdlac_pkg

// file: hdl/cdlac_grp_if.sv
// signals between the top and one event flag group
// assumes all members run on the top's aclk
interface cdlac_grp_if;
  logic       tick;
  logic       latch_en;
  logic [2:0] axis_en;
  logic [2:0] cond;
  logic       read_clr;
  logic [2:0] flags;
  logic       active;
  logic       new_evt;

  modport grp (input tick, latch_en, axis_en, cond, read_clr, output flags, active, new_evt);
  modport top (output tick, latch_en, axis_en, cond, read_clr, input flags, active, new_evt);
endinterface : cdlac_grp_if

// file: hdl/cdlac_event_group.sv
// per-axis flags and event-active flag for one window group
// assumes tick is a one-cycle odr pulse and read_clr a one-cycle read strobe
module cdlac_event_group (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // group link
  cdlac_grp_if.grp g
);
  import cdlac_pkg::*;

  logic [2:0] flags_q, flags_d;
  logic       active_q, active_d;
  logic       prev_q, prev_d;
  logic [2:0] hit;
  logic       cond_any;
  logic       rise;

  assign hit      = g.cond & g.axis_en;
  assign cond_any = |hit;
  assign rise     = g.tick & cond_any & ~prev_q;

  // next values; a new event beats a same-cycle read clear
  always_comb begin
    flags_d  = flags_q;
    active_d = active_q;
    prev_d   = prev_q;
    if (g.latch_en) begin
      if (g.read_clr) begin
        flags_d  = '0;
        active_d = 1'b0;
      end
      if (rise) begin
        flags_d  = flags_q & ~{CDLAC_AXES{g.read_clr}} | hit;
        active_d = 1'b1;
      end
    end else if (g.tick) begin
      flags_d  = hit;
      active_d = cond_any;
    end
    if (g.tick) begin
      prev_d = cond_any;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q  <= '0;
      active_q <= 1'b0;
      prev_q   <= 1'b0;
    end else if (ce) begin
      flags_q  <= flags_d;
      active_q <= active_d;
      prev_q   <= prev_d;
    end
  end

  assign g.flags   = flags_q;
  assign g.active  = active_q;
  assign g.new_evt = ce & active_d & ~active_q;
endmodule : cdlac_event_group

// file: hdl/cdlac_irq.sv
// sticky interrupt status with mask and one level output
// assumes set pulses and write-one-to-clear strobes on aclk
module cdlac_irq (
  // clock and reset
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             ce,
  // events and software
  input  wire logic [cdlac_pkg::CDLAC_IRQW-1:0] set,
  input  wire logic [cdlac_pkg::CDLAC_IRQW-1:0] clr,
  input  wire logic                             mask_we,
  input  wire logic [cdlac_pkg::CDLAC_IRQW-1:0] mask_wdata,
  // state
  output logic      [cdlac_pkg::CDLAC_IRQW-1:0] status,
  output logic      [cdlac_pkg::CDLAC_IRQW-1:0] mask,
  output logic                                  irq
);
  import cdlac_pkg::*;

  logic [CDLAC_IRQW-1:0] status_q, status_d;
  logic [CDLAC_IRQW-1:0] mask_q, mask_d;

  // set wins so no event is lost on a clear
  assign status_d = (status_q & ~clr) | set;
  assign mask_d   = mask_we ? mask_wdata : mask_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      mask_q   <= '0;
    end else if (ce) begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = |(status_q & mask_q);
endmodule : cdlac_irq

// file: hdl/cdlac_top.sv
// change-detect latch and axis config block with axi4-lite slave
// assumes synchronous comparator inputs and a one-cycle odr_tick pulse
module cdlac_top (
  // clock, reset, enable
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  // axi4-lite write address
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [cdlac_pkg::CDLAC_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  // axi4-lite write data
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [cdlac_pkg::CDLAC_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic      [1:0]                     s_axi_bresp,
  // axi4-lite read address
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [cdlac_pkg::CDLAC_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic      [cdlac_pkg::CDLAC_DW-1:0] s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  // sensor side
  input  wire logic                           boot_mode_strap,
  input  wire logic                           odr_tick,
  input  wire logic [2:0]                     axis_outside_cond,
  input  wire logic [2:0]                     axis_inside_cond,
  // detector state
  output logic      [2:0]                     axis_outside_flags,
  output logic      [2:0]                     axis_inside_flags,
  output logic                                outside_event_active,
  output logic                                inside_event_active,
  output logic                                irq
);
  import cdlac_pkg::*;

  // register index from a byte address
  function automatic logic [CDLAC_IW-1:0] reg_index(input logic [CDLAC_AW-1:0] addr);
    reg_index = addr[CDLAC_AW-1:2];
  endfunction : reg_index

  // source register image: active flag and x/y/z flags
  function automatic logic [7:0] src_pack(input logic active, input logic [2:0] flags);
    logic [7:0] v;
    v                   = 8'h00;
    v[CDLAC_SRC_ACTIVE] = active;
    v[CDLAC_SRC_X]      = flags[2];
    v[CDLAC_SRC_Y]      = flags[1];
    v[CDLAC_SRC_Z]      = flags[0];
    src_pack            = v;
  endfunction : src_pack

  // configuration register
  logic [7:0]            config_q, config_d;
  logic [7:0]            config_rst;

  // write channel state
  logic                  aw_got_q, aw_got_d;
  logic                  w_got_q, w_got_d;
  logic [CDLAC_IW-1:0]   aw_idx_q, aw_idx_d;
  logic [7:0]            w_byte_q, w_byte_d;
  logic                  w_lane_q, w_lane_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;

  // read channel state
  cdlac_rd_state_type    rd_state_q, rd_state_d;
  logic [CDLAC_DW-1:0]   rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;

  // decode wires
  logic                  aw_hs, w_hs, ar_hs;
  logic                  wr_fire;
  logic                  wr_lane_ok;
  logic                  wr_cfg, wr_status, wr_mask;
  logic                  wr_mapped;
  logic [CDLAC_IW-1:0]   ar_idx;
  logic                  rd_mapped;
  logic [7:0]            rd_byte;
  logic                  rd_out_src, rd_in_src;

  // group and interrupt wires
  logic [CDLAC_IRQW-1:0] irq_status, irq_mask, irq_set, irq_clr;
  logic                  tick;

  cdlac_grp_if out_grp ();
  cdlac_grp_if in_grp ();

  assign config_rst = boot_mode_strap ? CDLAC_CFG_RST_HIGH : CDLAC_CFG_RST_LOW;

  // handshakes; ce low stalls the bus as well as the detector
  assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ce & (rd_state_q == CDLAC_RD_IDLE);
  assign aw_hs         = s_axi_awvalid & s_axi_awready;
  assign w_hs          = s_axi_wvalid & s_axi_wready;
  assign ar_hs         = s_axi_arvalid & s_axi_arready;

  // write capture: address and data may arrive in either order
  assign aw_idx_d = aw_hs ? reg_index(s_axi_awaddr) : aw_idx_q;
  assign w_byte_d = w_hs ? s_axi_wdata[7:0] : w_byte_q;
  assign w_lane_d = w_hs ? s_axi_wstrb[0] : w_lane_q;
  assign wr_fire  = ce & (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~bvalid_q;
  assign aw_got_d = wr_fire ? 1'b0 : (aw_got_q | aw_hs);
  assign w_got_d  = wr_fire ? 1'b0 : (w_got_q | w_hs);

  // write decode on the merged address and data
  logic [CDLAC_IW-1:0] wr_idx;
  logic [7:0]          wr_byte;
  assign wr_idx     = aw_hs ? reg_index(s_axi_awaddr) : aw_idx_q;
  assign wr_byte    = w_hs ? s_axi_wdata[7:0] : w_byte_q;
  assign wr_lane_ok = w_hs ? s_axi_wstrb[0] : w_lane_q;
  assign wr_mapped  = (wr_idx == CDLAC_IDX_CONFIG) | (wr_idx == CDLAC_IDX_OUT_SRC) |
                      (wr_idx == CDLAC_IDX_IN_SRC) | (wr_idx == CDLAC_IDX_STATUS) |
                      (wr_idx == CDLAC_IDX_MASK);
  assign wr_cfg     = wr_fire & wr_lane_ok & (wr_idx == CDLAC_IDX_CONFIG);
  assign wr_status  = wr_fire & wr_lane_ok & (wr_idx == CDLAC_IDX_STATUS);
  assign wr_mask    = wr_fire & wr_lane_ok & (wr_idx == CDLAC_IDX_MASK);
  assign irq_clr    = wr_status ? wr_byte[CDLAC_IRQW-1:0] : '0;

  // stored now, used at next tick
  assign config_d = wr_cfg ? wr_byte : config_q;

  // write response; writes to source registers are ignored but acknowledged
  assign bvalid_d = wr_fire ? 1'b1 : (bvalid_q & ~s_axi_bready);
  assign bresp_d  = wr_fire ? (wr_mapped ? CDLAC_RESP_OKAY : CDLAC_RESP_SLVERR) : bresp_q;

  // config register and write channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_q <= config_rst;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_idx_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= CDLAC_RESP_OKAY;
    end else if (ce) begin
      config_q <= config_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      aw_idx_q <= aw_idx_d;
      w_byte_q <= w_byte_d;
      w_lane_q <= w_lane_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
    end
  end

  // read decode
  assign ar_idx     = reg_index(s_axi_araddr);
  assign rd_out_src = ar_hs & (ar_idx == CDLAC_IDX_OUT_SRC);
  assign rd_in_src  = ar_hs & (ar_idx == CDLAC_IDX_IN_SRC);
  assign rd_mapped  = (ar_idx == CDLAC_IDX_CONFIG) | (ar_idx == CDLAC_IDX_OUT_SRC) |
                      (ar_idx == CDLAC_IDX_IN_SRC) | (ar_idx == CDLAC_IDX_STATUS) |
                      (ar_idx == CDLAC_IDX_MASK);

  // read data mux; source registers show the flags before the clear
  always_comb begin
    rd_byte = 8'h00;
    case (ar_idx)
      CDLAC_IDX_CONFIG:  rd_byte = config_q;
      CDLAC_IDX_OUT_SRC: rd_byte = src_pack(out_grp.active, out_grp.flags);
      CDLAC_IDX_IN_SRC:  rd_byte = src_pack(in_grp.active, in_grp.flags);
      CDLAC_IDX_STATUS:  rd_byte = {{(8-CDLAC_IRQW){1'b0}}, irq_status};
      CDLAC_IDX_MASK:    rd_byte = {{(8-CDLAC_IRQW){1'b0}}, irq_mask};
      default:           rd_byte = 8'h00;
    endcase
  end

  // read channel state machine
  always_comb begin
    rd_state_d = rd_state_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    case (rd_state_q)
      CDLAC_RD_IDLE: begin
        if (ar_hs) begin
          rd_state_d = CDLAC_RD_RESP;
          rdata_d    = {{(CDLAC_DW-8){1'b0}}, rd_byte};
          rresp_d    = rd_mapped ? CDLAC_RESP_OKAY : CDLAC_RESP_SLVERR;
        end
      end
      CDLAC_RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_d = CDLAC_RD_IDLE;
        end
      end
      default: begin
        rd_state_d = CDLAC_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= CDLAC_RD_IDLE;
      rdata_q    <= '0;
      rresp_q    <= CDLAC_RESP_OKAY;
    end else if (ce) begin
      rd_state_q <= rd_state_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = (rd_state_q == CDLAC_RD_RESP);
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // group wiring from the live config
  assign tick              = ce & odr_tick;
  assign out_grp.tick      = tick;
  assign out_grp.latch_en  = config_q[CDLAC_BIT_OUT_LATCH];
  assign out_grp.axis_en   = config_q[CDLAC_OUT_AXIS_LSB +: CDLAC_AXES];
  assign out_grp.cond      = axis_outside_cond;
  assign out_grp.read_clr  = rd_out_src;
  assign in_grp.tick       = tick;
  assign in_grp.latch_en   = config_q[CDLAC_BIT_IN_LATCH];
  assign in_grp.axis_en    = config_q[CDLAC_IN_AXIS_LSB +: CDLAC_AXES];
  assign in_grp.cond       = axis_inside_cond;
  assign in_grp.read_clr   = rd_in_src;

  cdlac_event_group u_outside (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .g       (out_grp)
  );

  cdlac_event_group u_inside (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .g       (in_grp)
  );

  // interrupt events are the rising event-active flags
  assign irq_set[CDLAC_IRQ_OUT] = out_grp.new_evt;
  assign irq_set[CDLAC_IRQ_IN]  = in_grp.new_evt;

  cdlac_irq u_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .set        (irq_set),
    .clr        (irq_clr),
    .mask_we    (wr_mask),
    .mask_wdata (wr_byte[CDLAC_IRQW-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // detector state out
  assign axis_outside_flags   = out_grp.flags;
  assign axis_inside_flags    = in_grp.flags;
  assign outside_event_active = out_grp.active;
  assign inside_event_active  = in_grp.active;
endmodule : cdlac_top

// file: verification/cdlac_assertions.sv
// concurrent checks watching the cdlac_top ports
// assumes one aclk domain; bound onto every cdlac_top instance
module cdlac_assertions (
  // clock and reset
  input logic                  aclk,
  input logic                  aresetn,
  // register bus
  input logic                  s_axi_awvalid,
  input logic                  s_axi_awready,
  input logic                  s_axi_wvalid,
  input logic                  s_axi_wready,
  input logic                  s_axi_bvalid,
  input logic                  s_axi_bready,
  input logic [1:0]            s_axi_bresp,
  input logic                  s_axi_arvalid,
  input logic                  s_axi_arready,
  input logic                  s_axi_rvalid,
  input logic                  s_axi_rready,
  input logic [cdlac_pkg::CDLAC_DW-1:0] s_axi_rdata,
  input logic [1:0]            s_axi_rresp,
  // detector
  input logic                  odr_tick,
  input logic [2:0]            axis_outside_cond,
  input logic [2:0]            axis_inside_cond,
  input logic [2:0]            axis_outside_flags,
  input logic [2:0]            axis_inside_flags,
  input logic                  outside_event_active,
  input logic                  inside_event_active
);
  import cdlac_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus answers and holds
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
    else $error("read accepted while busy or wide data");
  // a flag newly set only by its own axis condition
  a_out_flag_cause: assert property ((axis_outside_flags & ~$past(axis_outside_flags) & ~$past(axis_outside_cond)) == 3'h0)
    else $error("outside flag set without condition");
  a_in_flag_cause: assert property ((axis_inside_flags & ~$past(axis_inside_flags) & ~$past(axis_inside_cond)) == 3'h0)
    else $error("inside flag set without condition");
  // flags move only at a tick or a read
  a_out_flag_moves: assert property (!$stable(axis_outside_flags) |-> $past(odr_tick || (s_axi_arvalid && s_axi_arready)))
    else $error("outside flags moved without cause");
  a_in_flag_moves: assert property (!$stable(axis_inside_flags) |-> $past(odr_tick || (s_axi_arvalid && s_axi_arready)))
    else $error("inside flags moved without cause");
  // active rises only at a tick with a true condition
  a_out_rise_tick: assert property ($rose(outside_event_active) |-> $past(odr_tick && (|axis_outside_cond)))
    else $error("outside active rose without tick");
  a_in_rise_tick: assert property ($rose(inside_event_active) |-> $past(odr_tick && (|axis_inside_cond)))
    else $error("inside active rose without tick");

  // main scenarios reached
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_out_event: cover property ($rose(outside_event_active));
  c_in_event: cover property ($rose(inside_event_active));
endmodule : cdlac_assertions

bind cdlac_top cdlac_assertions chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .odr_tick, .axis_outside_cond, .axis_inside_cond,
  .axis_outside_flags, .axis_inside_flags, .outside_event_active, .inside_event_active
);

// file: verification/tb.sv
// self-checking bench for cdlac_top over axi4-lite
// assumes the package, design and checker files compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cdlac_pkg::*;

  logic        aclk, aresetn, ce, odr_tick, boot_mode_strap, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        outside_event_active, inside_event_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot, axis_outside_cond, axis_inside_cond;
  logic [2:0]  axis_outside_flags, axis_inside_flags;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_fail, cmp_count;

  localparam logic [7:0] adr_cfg  = {CDLAC_IDX_CONFIG, 2'b00};
  localparam logic [7:0] adr_osrc = {CDLAC_IDX_OUT_SRC, 2'b00};
  localparam logic [7:0] adr_isrc = {CDLAC_IDX_IN_SRC, 2'b00};
  localparam logic [7:0] adr_sts  = {CDLAC_IDX_STATUS, 2'b00};
  localparam logic [7:0] adr_msk  = {CDLAC_IDX_MASK, 2'b00};
  localparam logic [1:0] ok       = CDLAC_RESP_OKAY;

  cdlac_top dut_u (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .boot_mode_strap, .odr_tick, .axis_outside_cond,
    .axis_inside_cond, .axis_outside_flags, .axis_inside_flags, .outside_event_active,
    .inside_event_active, .irq
  );

  // 125 mhz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done |= s_axi_awvalid && s_axi_awready;
      w_done |= s_axi_wvalid && s_axi_wready;
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // one odr evaluation with the given per-axis conditions
  task automatic tick(input logic [2:0] o, input logic [2:0] i);
    axis_outside_cond <= o;
    axis_inside_cond <= i;
    odr_tick <= 1'b1;
    @(posedge aclk);
    odr_tick <= 1'b0;
    @(posedge aclk);
  endtask : tick

  // {active, x, y, z} of each group
  task automatic obs(input logic [3:0] o, input logic [3:0] i);
    chk("outside", o, {outside_event_active, axis_outside_flags});
    chk("inside", i, {inside_event_active, axis_inside_flags});
  endtask : obs

  task automatic do_reset(input logic s);
    aresetn <= 1'b0;
    boot_mode_strap <= s;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // cuts a hang short; the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    give_verdict();
  end

  // main sequence
  initial begin
    {n_fail, cmp_count} = '0;
    {aresetn, odr_tick, boot_mode_strap, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot, axis_outside_cond, axis_inside_cond} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    do_reset(1'b0);
    rd("cfg", adr_cfg, 32'h00, ok);
    do_reset(1'b1);
    rd("cfg", adr_cfg, 32'h38, ok);
    wr(adr_cfg, 32'hff, ok);
    rd("cfg", adr_cfg, 32'hff, ok);
    // byte 0 strobe low: write acknowledged but dropped
    s_axi_wstrb <= 4'h0;
    wr(adr_cfg, 32'h00, ok);
    rd("cfg", adr_cfg, 32'hff, ok);
    s_axi_wstrb <= 4'hf;
    wr(8'h40, 32'h5a, CDLAC_RESP_SLVERR);
    rd("unmapped", 8'h40, 32'h00, CDLAC_RESP_SLVERR);
    $display("test registers done");
    // real time, x only enabled: y excluded
    wr(adr_cfg, 32'h20, ok);
    tick(3'h7, 3'h0);
    obs(4'hc, 4'h0);
    tick(3'h3, 3'h0);
    obs(4'h0, 4'h0);
    // latched outside, config change between ticks
    wr(adr_msk, 32'h3, ok);
    wr(adr_cfg, 32'hb8, ok);
    tick(3'h2, 3'h0);
    obs(4'ha, 4'h0);
    wr(adr_cfg, 32'ha8, ok);
    obs(4'ha, 4'h0);
    tick(3'h0, 3'h0);
    obs(4'ha, 4'h0);
    tick(3'h1, 3'h0);
    obs(4'hb, 4'h0);
    rd("outsrc", adr_osrc, 32'h8a, ok);
    obs(4'h0, 4'h0);
    chk("irq", 32'h1, irq);
    tick(3'h1, 3'h0);
    obs(4'h0, 4'h0);
    $display("test outside done");
    // status clear and mask
    rd("status", adr_sts, 32'h1, ok);
    wr(adr_sts, 32'h1, ok);
    chk("irq", 32'h0, irq);
    wr(adr_msk, 32'h0, ok);
    tick(3'h0, 3'h0);
    tick(3'h4, 3'h0);
    obs(4'hc, 4'h0);
    rd("status", adr_sts, 32'h1, ok);
    chk("irq", 32'h0, irq);
    wr(adr_sts, 32'h1, ok);
    $display("test interrupt done");
    // inside group: empty set, latched, real time
    wr(adr_cfg, 32'h40, ok);
    tick(3'h0, 3'h7);
    obs(4'h0, 4'h0);
    wr(adr_cfg, 32'h44, ok);
    tick(3'h0, 3'h4);
    obs(4'h0, 4'hc);
    tick(3'h0, 3'h0);
    obs(4'h0, 4'hc);
    rd("status", adr_sts, 32'h2, ok);
    rd("insrc", adr_isrc, 32'ha0, ok);
    obs(4'h0, 4'h0);
    wr(adr_cfg, 32'h03, ok);
    tick(3'h0, 3'h7);
    obs(4'h0, 4'hb);
    tick(3'h0, 3'h4);
    obs(4'h0, 4'h0);
    // clock enable low: a tick must not update anything
    ce <= 1'b0;
    tick(3'h7, 3'h3);
    obs(4'h0, 4'h0);
    ce <= 1'b1;
    $display("test inside done");
    give_verdict();
  end
endmodule : tb
